// ---- verilog/bmd_defs.vh ----
// Address map, field positions and reset values of the banked data memory decoder
`ifndef BMD_DEFS_VH
`define BMD_DEFS_VH

`define BMD_ADDR_WIN0       8'h00
`define BMD_ADDR_PTR0       8'h01
`define BMD_ADDR_WIN1       8'h02
`define BMD_ADDR_PTR1       8'h03
`define BMD_ADDR_BANK       8'h04
`define BMD_ADDR_GP_BASE    8'h40
`define BMD_ADDR_LCD_LAST   8'h9F
`define BMD_BANK_LCD        6'h1B
`define BMD_BANK_SIZE       12'h0C0
`define BMD_LOW_MSB         7
`define BMD_LOW_LSB         6
`define BMD_RESET_PTR       8'h00
`define BMD_RESET_BANK      6'h00
`define BMD_READ_EMPTY      8'h00
// One bit per bank-0 location 00H..3FH that is routed to a peripheral register
`define BMD_PERIPH_MASK     64'h00F0E157CF7FFFE0

`endif

// ---- verilog/bmd_ram.v ----
// Data storage: general purpose banks followed by the display memory
`timescale 1ns/10ps
module bmd_ram #(
  parameter DEPTH  = 2976,
  parameter ADDR_W = 12
) (
  input  wire              clk,
  input  wire              we,
  input  wire              re,
  input  wire [ADDR_W-1:0] addr,
  input  wire [7:0]        wdata,
  output reg  [7:0]        rdata
);

  reg [7:0] mem [0:DEPTH-1];

  // No reset on the array; contents are undefined until software writes them
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule // bmd_ram

// ---- verilog/bmd_banked_decoder.v ----
// Data memory decoder with two indirect windows, two pointers and a bank select
`timescale 1ns/10ps
`include "bmd_defs.vh"
module bmd_banked_decoder #(
  parameter BP_W      = 6,
  parameter NUM_BANKS = 15,
  parameter LCD_BYTES = 96,
  parameter RAM_AW    = 12
) (
  input  wire            clk,
  input  wire            sys_rst,
  input  wire [7:0]      core_addr,
  input  wire            core_rd,
  input  wire            core_wr,
  input  wire [7:0]      core_wdata,
  output wire [7:0]      core_rdata,
  output reg             core_rvalid,
  output wire [5:0]      periph_addr,
  output wire            periph_rd,
  output wire            periph_wr,
  output wire [7:0]      periph_wdata,
  input  wire [7:0]      periph_rdata,
  output reg  [7:0]      memory_pointer_zero,
  output reg  [7:0]      memory_pointer_one,
  output reg  [BP_W-1:0] ram_bank_select
);

  localparam SRC_ZERO = 4'b0001;
  localparam SRC_REG  = 4'b0010;
  localparam SRC_PER  = 4'b0100;
  localparam SRC_RAM  = 4'b1000;

  // Sized copies of the map constants so no expression below pads or drops bits
  localparam integer      LCD_BASE_I    = NUM_BANKS * `BMD_BANK_SIZE;
  localparam integer      RAM_DEPTH     = NUM_BANKS * `BMD_BANK_SIZE + LCD_BYTES;
  localparam [RAM_AW-1:0] LCD_BASE      = LCD_BASE_I[RAM_AW-1:0];
  localparam [RAM_AW-1:0] GP_BASE       = {{(RAM_AW-8){1'b0}}, `BMD_ADDR_GP_BASE};
  localparam [5:0]        LCD_BANK_FULL = `BMD_BANK_LCD;
  localparam [BP_W-1:0]   LCD_BANK      = LCD_BANK_FULL[BP_W-1:0];

  wire            is_win0;
  wire            is_win1;
  wire [7:0]      eff_off;
  wire [BP_W-1:0] eff_bank;
  wire            low_area;
  wire            hit_win;
  wire            hit_reg;
  wire            hit_per;
  wire            hit_gp;
  wire            hit_lcd;
  wire            ram_we;
  wire            ram_re;
  wire [7:0]      ram_q;
  wire [63:0]     per_mask;
  wire [NUM_BANKS-1:0] bank_hit;
  wire [RAM_AW-1:0] off_ext;
  wire [RAM_AW-1:0] bank_ext;
  wire [RAM_AW-1:0] gp_addr;
  wire [RAM_AW-1:0] lcd_addr;
  reg  [RAM_AW-1:0] ram_addr;
  reg  [3:0]      src;
  reg  [3:0]      next_src;
  reg  [7:0]      reg_q;
  reg  [7:0]      next_reg_q;
  reg  [7:0]      per_q;
  reg  [7:0]      rdata_mux;

  // Peripheral routing is a fixed map; locations outside it other than the pointer and bank registers read 00H
  assign per_mask = `BMD_PERIPH_MASK;

  // Window addresses are swapped for the pointer contents before any decode
  assign is_win0  = (core_addr == `BMD_ADDR_WIN0);
  assign is_win1  = (core_addr == `BMD_ADDR_WIN1);
  assign eff_off  = is_win0 ? memory_pointer_zero :
                    (is_win1 ? memory_pointer_one : core_addr);
  // Direct accesses and pointer zero are pinned to bank 0
  assign eff_bank = is_win1 ? ram_bank_select : {BP_W{1'b0}};

  // Below 40H the bank number is ignored, so every bank sees the bank-0 registers
  assign low_area = (eff_off[`BMD_LOW_MSB:`BMD_LOW_LSB] == 2'b00);
  assign hit_win  = low_area &&
                    (eff_off == `BMD_ADDR_WIN0 || eff_off == `BMD_ADDR_WIN1);
  assign hit_reg  = low_area && (eff_off == `BMD_ADDR_PTR0 ||
                    eff_off == `BMD_ADDR_PTR1 || eff_off == `BMD_ADDR_BANK);
  assign hit_per  = low_area && per_mask[eff_off[5:0]];
  assign hit_gp   = !low_area && (|bank_hit);
  assign hit_lcd  = !low_area && (eff_bank == LCD_BANK) &&
                    (eff_off <= `BMD_ADDR_LCD_LAST);

  // One comparator per implemented bank; a bank past the last, other than display bank 1BH, reads 00H and drops writes
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BANKS; gb = gb + 1) begin : g_bank
      localparam integer    BANK_I = gb;
      localparam [BP_W-1:0] BANK_N = BANK_I[BP_W-1:0];
      assign bank_hit[gb] = (eff_bank == BANK_N);
    end
  endgenerate

  // Offsets 40H..FFH fold down to 0..BFH inside each bank slot
  assign off_ext  = {{(RAM_AW-8){1'b0}}, eff_off};
  assign bank_ext = {{(RAM_AW-BP_W){1'b0}}, eff_bank};
  assign gp_addr  = bank_ext * `BMD_BANK_SIZE + off_ext - GP_BASE;
  assign lcd_addr = LCD_BASE + off_ext - GP_BASE;

  always @* begin
    if (hit_lcd) begin
      ram_addr = lcd_addr;
    end else begin
      ram_addr = gp_addr;
    end
  end

  // Only implemented storage is strobed, so a stray bank never aliases real RAM
  assign ram_we = core_wr && (hit_gp || hit_lcd);
  assign ram_re = core_rd && (hit_gp || hit_lcd);

  // Peripheral strobes follow the request in the same cycle
  assign periph_addr  = eff_off[5:0];
  assign periph_rd    = core_rd && hit_per;
  assign periph_wr    = core_wr && hit_per;
  assign periph_wdata = core_wdata;

  // Synchronous read keeps the array in block memory; its word lands with core_rvalid
  bmd_ram #(
    .DEPTH  (RAM_DEPTH),
    .ADDR_W (RAM_AW)
  ) u_ram (
    .clk   (clk),
    .we    (ram_we),
    .re    (ram_re),
    .addr  (ram_addr),
    .wdata (core_wdata),
    .rdata (ram_q)
  );

  // Pointers come up at zero so an early window access hits a defined place
  // Pointer and bank writes; a window hit never lands here
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      memory_pointer_zero <= `BMD_RESET_PTR;
      memory_pointer_one  <= `BMD_RESET_PTR;
      ram_bank_select     <= `BMD_RESET_BANK;
    end else if (core_wr && hit_reg) begin
      case (eff_off)
        `BMD_ADDR_PTR0: memory_pointer_zero <= core_wdata;
        `BMD_ADDR_PTR1: memory_pointer_one  <= core_wdata;
        `BMD_ADDR_BANK: ram_bank_select     <= core_wdata[BP_W-1:0];
        default:        memory_pointer_zero <= memory_pointer_zero;
      endcase
    end
  end

  // Bank select reads back zero-extended
  always @* begin
    next_reg_q = `BMD_READ_EMPTY;
    case (eff_off)
      `BMD_ADDR_PTR0: next_reg_q = memory_pointer_zero;
      `BMD_ADDR_PTR1: next_reg_q = memory_pointer_one;
      `BMD_ADDR_BANK: next_reg_q = {{(8-BP_W){1'b0}}, ram_bank_select};
      default:        next_reg_q = `BMD_READ_EMPTY;
    endcase
  end

  // Reserved, window and unmapped bank locations all answer with zero
  // A nested window resolves to nothing rather than chaining a second lookup
  always @* begin
    if (hit_win) begin
      next_src = SRC_ZERO;
    end else if (hit_reg) begin
      next_src = SRC_REG;
    end else if (hit_per) begin
      next_src = SRC_PER;
    end else if (hit_gp || hit_lcd) begin
      next_src = SRC_RAM;
    end else begin
      next_src = SRC_ZERO;
    end
  end

  // The far side must hold periph_rdata for the whole strobe cycle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      src         <= SRC_ZERO;
      reg_q       <= `BMD_READ_EMPTY;
      per_q       <= `BMD_READ_EMPTY;
      core_rvalid <= 1'b0;
    end else begin
      core_rvalid <= core_rd;
      if (core_rd) begin
        src   <= next_src;
        reg_q <= next_reg_q;
        per_q <= periph_rdata;
      end
    end
  end

  // Every source but SRC_ZERO is a flop; the mux only picks which one is shown
  always @* begin
    rdata_mux = `BMD_READ_EMPTY;
    case (src)
      SRC_REG:  rdata_mux = reg_q;
      SRC_PER:  rdata_mux = per_q;
      SRC_RAM:  rdata_mux = ram_q;
      SRC_ZERO: rdata_mux = `BMD_READ_EMPTY;
      default:  rdata_mux = `BMD_READ_EMPTY;
    endcase
  end

  assign core_rdata = rdata_mux;

endmodule // bmd_banked_decoder

// ---- verification/bmd_checker.sv ----
// Port assertions for the banked data memory decoder
`timescale 1ns/10ps
module bmd_checker #(parameter BP_W = 6) (
  input wire            clk, sys_rst, core_rd, core_wr, core_rvalid, periph_rd, periph_wr,
  input wire [7:0]      core_addr, core_wdata, core_rdata, periph_wdata, periph_rdata,
  input wire [7:0]      memory_pointer_zero, memory_pointer_one,
  input wire [5:0]      periph_addr,
  input wire [BP_W-1:0] ram_bank_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_read_answer: assert property (core_rd |=> core_rvalid)
    else $error("read not answered");
  chk_ptr_write: assert property (core_wr && core_addr == 8'h01 |=>
    memory_pointer_zero == $past(core_wdata)) else $error("pointer not loaded");
  chk_ptr1_write: assert property (core_wr && core_addr == 8'h03 |=>
    memory_pointer_one == $past(core_wdata)) else $error("pointer one not loaded");
  chk_bank_write: assert property (core_wr && core_addr == 8'h04 |=>
    ram_bank_select == $past(core_wdata[BP_W-1:0])) else $error("bank not loaded");
  chk_ctrl_route: assert property (core_rd && core_addr == 8'h26 |->
    periph_rd && periph_addr == 6'h26) else $error("control not routed");
  chk_reserved_zero: assert property (core_rd && core_addr == 8'h17 |=>
    core_rdata == 8'h00) else $error("reserved not zero");
  chk_win_zero: assert property (core_rd && core_addr == 8'h00 &&
    memory_pointer_zero == 8'h0D |-> periph_rd && periph_addr == 6'h0D) else $error("window 0");
  chk_low_alias: assert property (core_wr && core_addr == 8'h02 &&
    memory_pointer_one == 8'h1E |-> periph_wr && periph_addr == 6'h1E) else $error("alias");
  chk_periph_data: assert property (periph_rd |=> core_rdata == $past(periph_rdata))
    else $error("peripheral data lost");
  chk_nested_zero: assert property (core_rd && core_addr == 8'h02 &&
    memory_pointer_one == 8'h02 |=> core_rdata == 8'h00) else $error("nested not zero");
endmodule // bmd_checker

bind bmd_banked_decoder bmd_checker #(.BP_W(BP_W)) u_chk (.clk(clk), .sys_rst(sys_rst),
  .core_rd(core_rd), .core_wr(core_wr), .core_rvalid(core_rvalid), .periph_rd(periph_rd),
  .periph_wr(periph_wr), .core_addr(core_addr), .core_wdata(core_wdata),
  .core_rdata(core_rdata), .periph_wdata(periph_wdata), .periph_rdata(periph_rdata),
  .memory_pointer_zero(memory_pointer_zero), .memory_pointer_one(memory_pointer_one),
  .periph_addr(periph_addr), .ram_bank_select(ram_bank_select));

// ---- verification/bmd_periph_model.sv ----
// Peripheral register model answering the decoder's routed accesses
`timescale 1ns/10ps
module bmd_periph_model (
  input  wire       clk, periph_rd, periph_wr,
  input  wire [5:0] periph_addr,
  input  wire [7:0] periph_wdata,
  output wire [7:0] periph_rdata
);
  reg [7:0] regs [0:63];
  reg [7:0] noise = 8'h5A;
  // Idle data changes every cycle so a late sample cannot match by luck
  always @(posedge clk) begin
    noise <= ~noise + 8'h01;
    if (periph_wr) regs[periph_addr] <= periph_wdata;
  end
  assign periph_rdata = periph_rd ? regs[periph_addr] : noise;
endmodule // bmd_periph_model

// ---- verification/tb_banked_data_memory_indirect_access.sv ----
// Directed bench for the banked data memory decoder
`timescale 1ns/10ps
module tb_banked_data_memory_indirect_access;
  reg        clk = 0, sys_rst = 1, core_rd = 0, core_wr = 0;
  reg  [7:0] core_addr = 8'h00, core_wdata = 8'h00;
  wire [7:0] core_rdata, periph_wdata, periph_rdata;
  wire [5:0] periph_addr;
  wire       core_rvalid, periph_rd, periph_wr;
  integer    n_fail = 0, cmp_count = 0;
  always #25 clk = ~clk;
  bmd_banked_decoder dut (.clk(clk), .sys_rst(sys_rst), .core_addr(core_addr),
    .core_rd(core_rd), .core_wr(core_wr), .core_wdata(core_wdata), .core_rdata(core_rdata),
    .core_rvalid(core_rvalid), .periph_addr(periph_addr), .periph_rd(periph_rd),
    .periph_wr(periph_wr), .periph_wdata(periph_wdata), .periph_rdata(periph_rdata),
    .memory_pointer_zero(), .memory_pointer_one(), .ram_bank_select());
  bmd_periph_model peri (.clk(clk), .periph_rd(periph_rd), .periph_wr(periph_wr),
    .periph_addr(periph_addr), .periph_wdata(periph_wdata), .periph_rdata(periph_rdata));
  task w(input [7:0] a, input [7:0] d); begin
    @(posedge clk); #2 core_addr = a; core_wdata = d; core_wr = 1;
    @(posedge clk); #2 core_wr = 0;
  end endtask
  // Answer is registered on the taking edge, so it is checked 2 ns after that edge
  task r(input [7:0] a, input [7:0] e); begin
    @(posedge clk); #2 core_addr = a; core_rd = 1;
    @(posedge clk); #2 core_rd = 0;
    cmp_count = cmp_count + 1;
    if (core_rvalid !== 1'b1 || core_rdata !== e) begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: got %h expected %h", $time, core_rdata, e);
    end
  end endtask
  task results; begin
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  end endtask
  initial begin
    #200000 n_fail = n_fail + 1;
    results;
  end
  initial begin
    repeat (6) @(posedge clk);
    #2 sys_rst = 0;
    r(8'h01, 8'h00); r(8'h04, 8'h00);
    w(8'h04, 8'hFF); r(8'h04, 8'h3F);
    w(8'h01, 8'h0D); r(8'h01, 8'h0D);
    $display("test pointers done");
    w(8'h0D, 8'h33); r(8'h00, 8'h33);
    w(8'h26, 8'h5A); r(8'h26, 8'h5A);
    r(8'h17, 8'h00); r(8'h38, 8'h00);
    w(8'h03, 8'h1E); w(8'h02, 8'h77); r(8'h1E, 8'h77);
    w(8'h03, 8'h02); r(8'h02, 8'h00);
    w(8'h03, 8'h00); w(8'h02, 8'h55); r(8'h0D, 8'h33);
    $display("test registers done");
    w(8'h40, 8'h11); w(8'h03, 8'h40); w(8'h04, 8'h02); w(8'h02, 8'hC3);
    w(8'h04, 8'h0E); w(8'h02, 8'h3C); r(8'h02, 8'h3C);
    w(8'h04, 8'h02); r(8'h02, 8'hC3); r(8'h40, 8'h11);
    w(8'h04, 8'h0F); w(8'h02, 8'hAA); r(8'h02, 8'h00);
    w(8'h01, 8'h40); r(8'h00, 8'h11);
    w(8'h04, 8'h1B); w(8'h03, 8'h9F); w(8'h02, 8'hE7); r(8'h02, 8'hE7);
    w(8'h03, 8'hA0); w(8'h02, 8'h99); r(8'h02, 8'h00);
    $display("test banks done");
    results;
  end
endmodule // tb_banked_data_memory_indirect_access
